// ### hw/rsa_pkg.sv
// Operation
// [RQ1] Codes three to ten enable at that slot
// [RQ2] Other main codes leave rail uncontrolled
// [RQ3] Register 0x23 high nibble buck-boost, reset 7
// [RQ4] Low nibble buck three, reset 5, total 0x75
// [RQ5] Writes take effect only when password unlocked
// [RQ6] Register 0x24 backup b/a codes, reset 0x12
// [RQ7] Backup code 1 slot one, 2 slot two
// [RQ8] Slots one and two only while seal clear
// [RQ9] Broken seal: backup rails never turned off; reset still drops them
// [RQ10] Power-up walks slots in ascending order
package rsa_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RSA_OFS_MAIN = 8'h23;
  localparam logic [7:0] RSA_OFS_BACKUP = 8'h24;
  localparam logic [7:0] RSA_RST_MAIN = 8'h75;
  localparam logic [7:0] RSA_RST_BACKUP = 8'h12;
  localparam int RSA_HI_LSB = 4;
  localparam int RSA_LO_LSB = 0;
  // ----------------------------------------
  // Slot codes
  // ----------------------------------------
  localparam logic [3:0] RSA_SLOT_FIRST = 4'h1;
  localparam logic [3:0] RSA_SLOT_MAIN_MIN = 4'h3;
  localparam logic [3:0] RSA_SLOT_LAST = 4'hA;
  localparam logic [3:0] RSA_SLOT_NONE = 4'h0;
  localparam int RSA_RAILS = 4;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsa_wr_t;

  typedef enum logic [1:0] {RSA_IDLE, RSA_UP, RSA_DOWN} rsa_state_t;
endpackage

// ### hw/rsa_decode.sv
`timescale 1ns/10ps
module rsa_decode
  import rsa_pkg::*;
(
  input wire logic [3:0] code,
  input wire logic backup,
  output logic [3:0] slot
);
  always_comb begin
    slot = RSA_SLOT_NONE;
    if (backup) begin
      if (code == 4'h1 || code == 4'h2) begin
        slot = code; // see [RQ7]
      end
    end else if (code >= RSA_SLOT_MAIN_MIN && code <= RSA_SLOT_LAST) begin
      slot = code; // see [RQ1] see [RQ2]
    end
  end
endmodule

// ### hw/rsa_top.sv
`timescale 1ns/10ps
module rsa_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire rsa_pkg::rsa_wr_t wr_req,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic unlocked,
  input wire logic freshness_seal_bit,
  input wire logic power_up,
  input wire logic power_down,
  output logic [3:0] cur_slot,
  output logic busy,
  output logic [3:0] rail_en
);
  import rsa_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] main_ff, nxt_main;
  logic [7:0] backup_ff, nxt_backup;
  logic [7:0] rd_ff, nxt_rd;

  always_comb begin
    nxt_main = main_ff;
    nxt_backup = backup_ff;
    if (wr_req.wr && unlocked) begin // see [RQ5]
      if (wr_req.addr == RSA_OFS_MAIN) begin
        nxt_main = wr_req.wdata; // see [RQ3] see [RQ4]
      end
      if (wr_req.addr == RSA_OFS_BACKUP) begin
        nxt_backup = wr_req.wdata; // see [RQ6]
      end
    end
    case (rd_addr)
      RSA_OFS_MAIN: nxt_rd = main_ff;
      RSA_OFS_BACKUP: nxt_rd = backup_ff;
      default: nxt_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      main_ff <= RSA_RST_MAIN; // see [RQ3] see [RQ4]
      backup_ff <= RSA_RST_BACKUP; // see [RQ6]
      rd_ff <= 8'h00;
    end else if (ce) begin
      main_ff <= nxt_main;
      backup_ff <= nxt_backup;
      rd_ff <= nxt_rd;
    end
  end
  assign rd_data = rd_ff;

  // ----------------------------------------
  // Slot decode, rail 0 buck-boost, 1 buck three, 2 backup a, 3 backup b
  // ----------------------------------------
  logic [3:0] code [RSA_RAILS];
  logic [3:0] slot [RSA_RAILS];
  assign code[0] = main_ff[RSA_HI_LSB +: 4];
  assign code[1] = main_ff[RSA_LO_LSB +: 4];
  assign code[2] = backup_ff[RSA_LO_LSB +: 4];
  assign code[3] = backup_ff[RSA_HI_LSB +: 4];

  genvar gi;
  generate
    for (gi = 0; gi < RSA_RAILS; gi++) begin : g_dec
      rsa_decode u_dec (
        .code(code[gi]),
        .backup(gi >= 2),
        .slot(slot[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Strobe walker
  // ----------------------------------------
  rsa_state_t st_ff, nxt_st;
  logic [3:0] slot_ff, nxt_slot;
  logic [3:0] en_ff, nxt_en;
  logic seal_s1_ff, seal_ff, up_s1_ff, up_ff, dn_s1_ff, dn_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      seal_s1_ff <= 1'b0;
      seal_ff <= 1'b0;
      up_s1_ff <= 1'b0;
      up_ff <= 1'b0;
      dn_s1_ff <= 1'b0;
      dn_ff <= 1'b0;
    end else if (ce) begin
      seal_s1_ff <= freshness_seal_bit;
      seal_ff <= seal_s1_ff;
      up_s1_ff <= power_up;
      up_ff <= up_s1_ff;
      dn_s1_ff <= power_down;
      dn_ff <= dn_s1_ff;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_slot = slot_ff;
    nxt_en = en_ff;
    case (st_ff)
      RSA_IDLE: begin
        if (up_ff) begin
          nxt_st = RSA_UP;
          // Sealed parts start past the backup slots
          nxt_slot = seal_ff ? RSA_SLOT_MAIN_MIN : RSA_SLOT_FIRST; // see [RQ8]
        end else if (dn_ff) begin
          nxt_st = RSA_DOWN;
          nxt_slot = RSA_SLOT_LAST;
        end
      end
      RSA_UP: begin
        for (int i = 0; i < RSA_RAILS; i++) begin
          if (slot[i] == slot_ff && slot[i] != RSA_SLOT_NONE) begin
            nxt_en[i] = 1'b1; // see [RQ10]
          end
        end
        if (slot_ff == RSA_SLOT_LAST) begin
          nxt_st = RSA_IDLE;
        end else begin
          nxt_slot = slot_ff + 4'h1; // see [RQ10]
        end
      end
      RSA_DOWN: begin
        for (int i = 0; i < RSA_RAILS; i++) begin
          if (slot[i] == slot_ff && slot[i] != RSA_SLOT_NONE) begin
            if (!(i >= 2 && seal_ff)) begin
              nxt_en[i] = 1'b0; // see [RQ9]
            end
          end
        end
        // Backup slots are skipped once sealed
        if (slot_ff == RSA_SLOT_FIRST || (seal_ff && slot_ff == RSA_SLOT_MAIN_MIN)) begin
          nxt_st = RSA_IDLE; // see [RQ8]
        end else begin
          nxt_slot = slot_ff - 4'h1;
        end
      end
      default: nxt_st = RSA_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= RSA_IDLE;
      slot_ff <= RSA_SLOT_NONE;
      en_ff <= 4'h0;
    end else if (ce) begin
      st_ff <= nxt_st;
      slot_ff <= nxt_slot;
      en_ff <= nxt_en;
    end
  end

  assign rail_en = en_ff;
  assign cur_slot = slot_ff;
  assign busy = (st_ff != RSA_IDLE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_locked_write;
    @(posedge clock) disable iff (rst)
    (ce && wr_req.wr && !unlocked) |=> $stable(main_ff) && $stable(backup_ff);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write landed"); // see [RQ5]

  // Both backup rails, not just one, must survive a sealed power-down
  property p_backup_hold;
    @(posedge clock) disable iff (rst)
    (seal_ff && $past(seal_ff)) |-> (rail_en[3:2] & $past(rail_en[3:2])) == $past(rail_en[3:2]);
  endproperty
  a_backup_hold: assert property (p_backup_hold) else $error("sealed backup dropped"); // see [RQ9]

  property p_sealed_skip;
    @(posedge clock) disable iff (rst)
    (st_ff == RSA_UP && seal_ff) |-> slot_ff >= RSA_SLOT_MAIN_MIN;
  endproperty
  a_sealed_skip: assert property (p_sealed_skip) else $error("backup slot run when sealed"); // see [RQ8]

  property p_up_order;
    @(posedge clock) disable iff (rst)
    (ce && st_ff == RSA_UP && slot_ff != RSA_SLOT_LAST) |=> slot_ff == $past(slot_ff) + 4'h1;
  endproperty
  a_up_order: assert property (p_up_order) else $error("slot not ascending"); // see [RQ10]

  property p_up_only_set;
    @(posedge clock) disable iff (rst)
    (st_ff == RSA_UP) |=> ($past(rail_en) & ~rail_en) == 4'h0;
  endproperty
  a_up_only_set: assert property (p_up_only_set) else $error("rail dropped in power-up"); // see [RQ10]

  // A low enable must hold both registers and the walker state and enables
  property p_ce_freeze;
    @(posedge clock) disable iff (rst)
    !ce |=> $stable(st_ff) && $stable(en_ff) && $stable(main_ff) && $stable(backup_ff);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  property p_bad_code;
    @(posedge clock) disable iff (rst)
    (code[0] > RSA_SLOT_LAST) |-> slot[0] == RSA_SLOT_NONE;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code mapped"); // see [RQ2]

  property p_good_code;
    @(posedge clock) disable iff (rst)
    (code[1] >= RSA_SLOT_MAIN_MIN && code[1] <= RSA_SLOT_LAST) |-> slot[1] == code[1];
  endproperty
  a_good_code: assert property (p_good_code) else $error("good code lost"); // see [RQ1]

  property p_backup_code;
    @(posedge clock) disable iff (rst)
    (code[3] == 4'h3) |-> slot[3] == RSA_SLOT_NONE;
  endproperty
  a_backup_code: assert property (p_backup_code) else $error("backup code 3 mapped"); // see [RQ7]

  property p_reset_val;
    @(posedge clock) rst |=> main_ff == RSA_RST_MAIN && backup_ff == RSA_RST_BACKUP;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong"); // see [RQ3] see [RQ6]
endmodule

// ### tb/rsa_rail_model.sv
`timescale 1ns/10ps
// Power stage: good flag only after a ramp, dropped at once on disable
module rsa_rail_model #(
  parameter int RAMP = 2
) (
  input wire logic clock,
  input wire logic [3:0] rail_en,
  output logic [3:0] pgood
);
  int cnt [4] = '{default: 0};
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = rail_en[i] ? cnt[i] + 1 : 0;
      pgood[i] <= rail_en[i] && cnt[i] > RAMP;
    end
  end
endmodule

// ### tb/rail_strobe_assignment_test.sv
`timescale 1ns/10ps
module rail_strobe_assignment_test;
  import rsa_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic ce = 1;
  logic unlocked = 0;
  logic seal = 0;
  logic pu = 0;
  logic pd = 0;
  logic look = 0;
  rsa_wr_t wr_req = '0;
  logic [7:0] rd_addr = '0;
  logic [7:0] rd_data, m, b, e;
  logic [3:0] cur_slot, rail_en, pgood;
  logic busy;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'hFA0AFC7E;
  logic [7:0] q[$];

  always #20 clock = ~clock;

  rsa_top dut_u (.clock(clock), .rst(rst), .ce(ce), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .unlocked(unlocked), .freshness_seal_bit(seal), .power_up(pu),
    .power_down(pd), .cur_slot(cur_slot), .busy(busy), .rail_en(rail_en));
  rsa_rail_model #(.RAMP(3)) rail_u (.clock(clock), .rail_en(rail_en), .pgood(pgood));

  task automatic stop_test();
    mismatches += q.size();
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] x, input logic [7:0] s);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] rd_data exp %h got %h", x, s);
    end
  endtask

  task automatic cmp_rail(input string nm, input logic [3:0] x, input logic [3:0] s);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, x, s);
    end
  endtask

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clock) begin : watch
    logic lk;
    logic bz;
    lk = look;
    bz = busy;
    #2;
    if (lk && q.size() > 0) cmp_rd(q.pop_front(), rd_data);
    if (bz === 1'b1 && busy === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      cmp_rail("rail_en", e[3:0], rail_en);
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      stop_test();
    end
  end

  // Strobes stay up between like transfers; the next other task drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    look = 1'b0;
    wr_req = '{1'b1, a, d};
    @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wr_req.wr = 1'b0;
    rd_addr = a;
    look = 1;
    q.push_back(x);
    @(posedge clock);
    #1;
  endtask

  // Level request is dropped after four clocks, by then busy, else it would restart when idle
  task automatic seq(input logic up, input logic [3:0] x);
    wr_req.wr = 1'b0;
    look = 1'b0;
    pu = up;
    pd = !up;
    q.push_back({4'h0, x});
    repeat (4) @(posedge clock);
    #1 pu = 0;
    pd = 0;
    while (busy === 1'b1) @(negedge clock);
    @(posedge clock);
    #1;
    // Good flags only rise if the enables stood through the ramp
    repeat (5) @(posedge clock);
    #1 cmp_rail("pgood", x, pgood);
  endtask

  function automatic logic [3:0] en_of(input logic [7:0] mm, input logic [7:0] bb, input logic s);
    en_of[0] = mm[7:4] >= 4'h3 && mm[7:4] <= 4'hA;
    en_of[1] = mm[3:0] >= 4'h3 && mm[3:0] <= 4'hA;
    en_of[2] = !s && (bb[3:0] == 4'h1 || bb[3:0] == 4'h2);
    en_of[3] = !s && (bb[7:4] == 4'h1 || bb[7:4] == 4'h2);
  endfunction

  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 0;
    rd(RSA_OFS_MAIN, 8'h75);
    rd(RSA_OFS_BACKUP, 8'h12);
    rd(8'h25, 8'h00);
    wr(RSA_OFS_MAIN, 8'h00);
    rd(RSA_OFS_MAIN, 8'h75);
    unlocked = 1;
    for (int i = 0; i < 6; i++) begin
      m = i == 0 ? 8'h3A : i == 1 ? 8'h2B : $random(seed);
      b = i == 0 ? 8'h21 : i == 1 ? 8'h30 : $random(seed);
      wr(RSA_OFS_MAIN, m);
      wr(RSA_OFS_BACKUP, b);
      rd(RSA_OFS_MAIN, m);
      rd(RSA_OFS_BACKUP, b);
      seq(1, en_of(m, b, 0));
      seq(0, 4'h0);
    end
    // A write with the enable low must not land
    ce = 0;
    wr(RSA_OFS_MAIN, ~m);
    ce = 1;
    rd(RSA_OFS_MAIN, m);
    wr(RSA_OFS_BACKUP, 8'h12);
    seq(1, en_of(m, 8'h12, 0));
    seal = 1;
    repeat (3) @(posedge clock);
    #1 seq(0, 4'hC);
    seq(1, en_of(m, 8'h12, 1) | 4'hC);
    // Reset drops the rails but the seal stays, so backups must stay off
    rst = 1;
    repeat (3) @(posedge clock);
    #1 rst = 0;
    rd(RSA_OFS_BACKUP, RSA_RST_BACKUP);
    seq(1, en_of(RSA_RST_MAIN, RSA_RST_BACKUP, 1));
    stop_test();
  end
endmodule
